// file: core/txms_core.sv
// Operation
// RL1 - fcs inhibit sends last four buffer bytes
// RL2 - host builds check field when inhibited
// RL3 - data bytes lsb first, check msb first
// RL4 - inhibit affects transmit path only
// RL5 - 16-bit remaining-byte count, read/write
// RL6 - software leaves remaining count alone mid-transfer
// RL7 - table limit holds address bits 15..8
// RL8 - fifo free counter, 10h empty, resets zero
// RL9 - 16-bit frame pointer, resets zero
// RL10 - host starts frames on 256-byte pages
// RL11 - status cleared before each packet
// RL12 - chained mode clears only at chain start
// RL13 - late collision sets bit 7, aborts
// RL14 - heartbeat bit 6, cleared by collision window
// RL15 - underrun bit 5 on starved serializer
// RL16 - early check underrun on dma overtaking host
// RL17 - carrier loss bit 4, transmission continues
// RL18 - excessive collisions set bit 3
// RL19 - bit 2 when collided, not on aborts
// RL20 - bit 1 when sent without deferral
// RL21 - bit 0 when sent without excess or underrun
// RL22 - host loads descriptor pointer at table build
// RL23 - host length includes check field when inhibited
// RL24 - free counter tracks pushes and pops, 0..16
`include "txms_consts.svh"

module txms_core
	import txms_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [8:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bit_tick,
	input  wire logic        tx_pkt_start,
	input  wire logic        tx_retry,
	input  wire logic        tx_chain_start,
	input  wire logic        tx_deferred,
	input  wire logic        tx_excess_abort,
	input  wire logic        tx_byte_valid,
	input  wire logic [7:0]  tx_byte,
	input  wire logic        tx_byte_last,
	output logic             tx_byte_pop,
	input  wire logic        dma_byte_push,
	input  wire logic        dma_done,
	input  wire logic        dma_active,
	input  wire logic [15:0] dma_rd_addr,
	input  wire logic [15:0] host_wr_addr,
	input  wire logic        collision_pin,
	input  wire logic        carrier_pin,
	output logic             tx_data,
	output logic             tx_enable,
	output logic             tx_pkt_done,
	output logic [15:0]      frame_ptr,
	output logic [15:0]      desc_ptr,
	output logic [7:0]       table_base,
	output logic [7:0]       table_limit,
	output logic [15:0]      remain_count,
	output logic             fcs_inhibit
);

	txms_regs_t q;
	txms_regs_t next_q;

	logic [1:0] page;
	logic [4:0] index;
	logic       setup;
	logic       access;
	logic       wr;
	logic       tick;
	logic       active;

	assign page   = paddr[8:7];
	assign index  = paddr[6:2];
	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign wr     = clk_en & access & pwrite & ~q.err;
	assign tick   = clk_en & bit_tick;
	assign active = (q.state == TXMS_DATA) || (q.state == TXMS_FCS);

	assign prdata       = q.rdata;
	assign pready       = access;
	assign pslverr      = access & q.err;
	assign tx_data      = q.tx_bit;
	assign tx_enable    = q.tx_en;
	assign tx_pkt_done  = q.done;
	assign frame_ptr    = q.frame_ptr;
	assign desc_ptr     = q.desc_ptr;
	assign table_base   = q.table_base;
	assign table_limit  = q.table_limit;
	assign remain_count = q.remain;
	assign fcs_inhibit  = q.ctrl[`TXMS_CTL_FCS_INHIBIT]; // RL4

	// byte taken from the fifo whenever the serializer waits for one and tx_byte_valid is set
	assign tx_byte_pop = clk_en & (q.state == TXMS_LOAD) & tx_byte_valid;

	always_comb begin
		logic       fb;
		logic       hit;
		logic       ro;
		logic [7:0] rd;
		logic       fin;
		logic       cut;
		fb  = 1'b0;
		hit = 1'b1;
		ro  = 1'b0;
		rd  = `TXMS_BYTE_ZERO;
		fin = 1'b0;
		cut = 1'b0;
		next_q = q;
		next_q.done = 1'b0;

		// pin synchronisers
		next_q.col_s1   = collision_pin;
		next_q.col_s2   = q.col_s1;
		next_q.crs_s1   = carrier_pin;
		next_q.crs_s2   = q.crs_s1;
		next_q.crs_prev = q.crs_s2;

		// fifo free space, clamped to its range
		if (dma_byte_push && !tx_byte_pop && q.fifo_free != `TXMS_FIFO_FREE_RESET) begin
			next_q.fifo_free = q.fifo_free - 5'h01; // RL24
		end else if (tx_byte_pop && !dma_byte_push && q.fifo_free != `TXMS_FIFO_FREE_EMPTY) begin
			next_q.fifo_free = q.fifo_free + 5'h01; // RL24
		end

		if (dma_byte_push && q.remain != `TXMS_WORD_ZERO) begin
			next_q.remain = q.remain - 16'h0001; // RL5
		end

		// heartbeat window after the end of a packet
		if (q.hb_on) begin
			if (q.col_s2) begin
				next_q.status[`TXMS_ST_HEARTBEAT] = 1'b0; // RL14
				next_q.hb_on = 1'b0;
			end else if (q.hb_cnt == 9'(`TXMS_HB_CYCLES - 1)) begin
				next_q.hb_on = 1'b0; // RL14
			end else begin
				next_q.hb_cnt = q.hb_cnt + 9'h001;
			end
		end

		if (active) begin
			if (q.crs_s2 && !q.crs_prev) begin
				next_q.crs_armed = 1'b1; // RL17
			end
			if (q.crs_armed && !q.crs_s2) begin
				next_q.status[`TXMS_ST_CARRIER_DROP] = 1'b1; // RL17
			end
			if (q.ctrl[`TXMS_CTL_EARLY_CHECK] && dma_active && dma_rd_addr >= host_wr_addr) begin
				next_q.status[`TXMS_ST_UNDERRUN] = 1'b1; // RL16
			end
			if (tick && q.slot_cnt != 10'(`TXMS_SLOT_BITS)) begin
				next_q.slot_cnt = q.slot_cnt + 10'h001;
			end
		end

		case (q.state)
			TXMS_IDLE: begin
				// the last bit keeps tx_enable for its whole bit period
				if (tick) begin
					next_q.tx_en = 1'b0;
				end
				if (tx_pkt_start) begin
					if (!tx_retry && (!q.ctrl[`TXMS_CTL_CHAINED] || tx_chain_start)) begin
						next_q.status = `TXMS_BYTE_ZERO; // RL11 RL12
					end
					if (!tx_retry) begin
						next_q.col_any  = 1'b0;
						next_q.deferred = tx_deferred; // RL20
						next_q.remain   = q.length;
					end
					next_q.status[`TXMS_ST_HEARTBEAT] = 1'b1; // RL14
					next_q.hb_on     = 1'b0;
					next_q.crc       = `TXMS_CRC_INIT;
					next_q.slot_cnt  = 10'h000;
					next_q.crs_armed = 1'b0;
					next_q.state     = TXMS_LOAD;
				end
			end
			TXMS_LOAD: begin
				if (tx_byte_valid) begin
					next_q.shift   = tx_byte;
					next_q.last    = tx_byte_last;
					next_q.bit_num = 3'h0;
					next_q.state   = TXMS_DATA;
				end else if (tick && !dma_done) begin
					next_q.status[`TXMS_ST_UNDERRUN] = 1'b1; // RL15
					next_q.state = TXMS_IDLE;
					next_q.done  = 1'b1;
					cut = 1'b1;
				end else if (tick) begin
					fin = 1'b1;
					cut = 1'b1;
				end
			end
			TXMS_DATA: begin
				if (tick) begin
					next_q.tx_en   = 1'b1;
					next_q.tx_bit  = q.shift[0]; // RL3
					next_q.shift   = {1'b0, q.shift[7:1]};
					next_q.bit_num = q.bit_num + 3'h1;
					fb = q.crc[31] ^ q.shift[0];
					next_q.crc = {q.crc[30:0], 1'b0} ^ (fb ? `TXMS_CRC_POLY : 32'h00000000);
					if (q.bit_num == `TXMS_LAST_BIT) begin
						if (!q.last) begin
							next_q.state = TXMS_LOAD;
						end else if (q.ctrl[`TXMS_CTL_FCS_INHIBIT]) begin
							fin = 1'b1; // RL1
						end else begin
							next_q.fcs_num = 5'h00;
							next_q.state   = TXMS_FCS;
						end
					end
				end
			end
			TXMS_FCS: begin
				if (tick) begin
					next_q.tx_en   = 1'b1;
					next_q.tx_bit  = ~q.crc[31]; // RL3
					next_q.crc     = {q.crc[30:0], 1'b1};
					next_q.fcs_num = q.fcs_num + 5'h01;
					if (q.fcs_num == `TXMS_LAST_FCS_BIT) begin
						fin = 1'b1;
					end
				end
			end
			default: begin
				next_q.state = TXMS_IDLE;
			end
		endcase

		// done comes with the last bit, which still has one bit period to run
		if (fin) begin
			next_q.state = TXMS_IDLE;
			next_q.done  = 1'b1;
			next_q.hb_on  = 1'b1; // RL14
			next_q.hb_cnt = 9'h000;
			if (!q.status[`TXMS_ST_UNDERRUN]) begin
				next_q.status[`TXMS_ST_SENT] = 1'b1; // RL21
			end
			if (q.col_any) begin
				next_q.status[`TXMS_ST_WITH_COL] = 1'b1; // RL19
			end
			if (!q.deferred) begin
				next_q.status[`TXMS_ST_NO_DEFER] = 1'b1; // RL20
			end
		end

		// collisions and aborts override a normal end of frame
		if (q.state != TXMS_IDLE && q.col_s2) begin
			cut = 1'b1;
			next_q.state = TXMS_IDLE;
			next_q.done  = 1'b1;
			next_q.hb_on = 1'b0;
			next_q.status[`TXMS_ST_SENT]     = 1'b0;
			next_q.status[`TXMS_ST_WITH_COL] = 1'b0;
			next_q.status[`TXMS_ST_NO_DEFER] = 1'b0;
			if (q.slot_cnt == 10'(`TXMS_SLOT_BITS)) begin
				next_q.status[`TXMS_ST_LATE_COL] = 1'b1; // RL13
				next_q.col_any = 1'b0; // RL19
			end else begin
				next_q.col_any = 1'b1;
			end
		end
		if (tx_excess_abort) begin
			// an abort ends the attempt like any other, so it pulses done
			if (q.state != TXMS_IDLE) begin
				next_q.done = 1'b1;
			end
			cut = 1'b1;
			next_q.state = TXMS_IDLE;
			next_q.hb_on = 1'b0;
			next_q.col_any = 1'b0; // RL19
			next_q.status[`TXMS_ST_ABORT]    = 1'b1; // RL18
			next_q.status[`TXMS_ST_SENT]     = 1'b0; // RL21
			next_q.status[`TXMS_ST_WITH_COL] = 1'b0;
		end
		// a cut frame drops tx_enable at once
		if (cut) begin
			next_q.tx_en = 1'b0;
		end

		// register read mux and decode, captured in the setup cycle
		case ({page, index})
			{`TXMS_PAGE_STATUS, `TXMS_IDX_EVENT_STATUS}: begin
				rd = q.status;
				ro = 1'b1;
			end
			{`TXMS_PAGE_STATUS, `TXMS_IDX_DESC_PTR_LO}: rd = q.desc_ptr[7:0];
			{`TXMS_PAGE_STATUS, `TXMS_IDX_DESC_PTR_HI}: rd = q.desc_ptr[15:8];
			{`TXMS_PAGE_TABLE, `TXMS_IDX_TABLE_LIMIT}:  rd = q.table_limit;
			{`TXMS_PAGE_TABLE, `TXMS_IDX_TABLE_BASE}:   rd = q.table_base;
			{`TXMS_PAGE_TABLE, `TXMS_IDX_REMAIN_LO}:    rd = q.remain[7:0];
			{`TXMS_PAGE_TABLE, `TXMS_IDX_REMAIN_HI}:    rd = q.remain[15:8];
			{`TXMS_PAGE_FRAME, `TXMS_IDX_FRAME_PTR_HI}: rd = q.frame_ptr[15:8];
			{`TXMS_PAGE_FRAME, `TXMS_IDX_FRAME_PTR_LO}: rd = q.frame_ptr[7:0];
			{`TXMS_PAGE_FRAME, `TXMS_IDX_FIFO_FREE}: begin
				rd = {3'h0, q.fifo_free}; // RL8
				ro = 1'b1;
			end
			{`TXMS_PAGE_CTRL, `TXMS_IDX_CONTROL}:   rd = {5'h00, q.ctrl};
			{`TXMS_PAGE_CTRL, `TXMS_IDX_LENGTH_LO}: rd = q.length[7:0];
			{`TXMS_PAGE_CTRL, `TXMS_IDX_LENGTH_HI}: rd = q.length[15:8];
			default: hit = 1'b0;
		endcase
		if (setup) begin
			next_q.rdata = {24'h000000, rd};
			next_q.err   = ~hit | (paddr[1:0] != 2'h0) | (ro & pwrite);
		end

		if (wr) begin
			case ({page, index})
				{`TXMS_PAGE_STATUS, `TXMS_IDX_DESC_PTR_LO}: next_q.desc_ptr[7:0]  = pwdata[7:0];
				{`TXMS_PAGE_STATUS, `TXMS_IDX_DESC_PTR_HI}: next_q.desc_ptr[15:8] = pwdata[7:0];
				{`TXMS_PAGE_TABLE, `TXMS_IDX_TABLE_LIMIT}:  next_q.table_limit = pwdata[7:0]; // RL7
				{`TXMS_PAGE_TABLE, `TXMS_IDX_TABLE_BASE}:   next_q.table_base  = pwdata[7:0];
				{`TXMS_PAGE_TABLE, `TXMS_IDX_REMAIN_LO}:    next_q.remain[7:0]  = pwdata[7:0]; // RL5
				{`TXMS_PAGE_TABLE, `TXMS_IDX_REMAIN_HI}:    next_q.remain[15:8] = pwdata[7:0]; // RL5
				{`TXMS_PAGE_FRAME, `TXMS_IDX_FRAME_PTR_HI}: next_q.frame_ptr[15:8] = pwdata[7:0]; // RL9
				{`TXMS_PAGE_FRAME, `TXMS_IDX_FRAME_PTR_LO}: next_q.frame_ptr[7:0]  = pwdata[7:0]; // RL9
				{`TXMS_PAGE_CTRL, `TXMS_IDX_CONTROL}:       next_q.ctrl = pwdata[2:0];
				{`TXMS_PAGE_CTRL, `TXMS_IDX_LENGTH_LO}:     next_q.length[7:0]  = pwdata[7:0];
				{`TXMS_PAGE_CTRL, `TXMS_IDX_LENGTH_HI}:     next_q.length[15:8] = pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0; // RL8 RL9
			q.state <= TXMS_IDLE;
			q.crc   <= `TXMS_CRC_INIT;
		end else if (clk_en) begin
			q <= next_q;
		end
	end

endmodule

// file: core/txms_consts.svh
`ifndef TXMS_CONSTS_SVH
`define TXMS_CONSTS_SVH

// register map: byte address = page * 0x80 + index * 4
`define TXMS_PAGE_STATUS      2'h0
`define TXMS_PAGE_TABLE       2'h1
`define TXMS_PAGE_FRAME       2'h2
`define TXMS_PAGE_CTRL        2'h3
`define TXMS_IDX_EVENT_STATUS 5'h14
`define TXMS_IDX_DESC_PTR_LO  5'h1a
`define TXMS_IDX_DESC_PTR_HI  5'h1b
`define TXMS_IDX_TABLE_LIMIT  5'h14
`define TXMS_IDX_TABLE_BASE   5'h13
`define TXMS_IDX_REMAIN_LO    5'h1a
`define TXMS_IDX_REMAIN_HI    5'h1b
`define TXMS_IDX_FRAME_PTR_HI 5'h14
`define TXMS_IDX_FRAME_PTR_LO 5'h15
`define TXMS_IDX_FIFO_FREE    5'h1e
`define TXMS_IDX_CONTROL      5'h1d
`define TXMS_IDX_LENGTH_LO    5'h16
`define TXMS_IDX_LENGTH_HI    5'h17

// control register fields
`define TXMS_CTL_FCS_INHIBIT  0
`define TXMS_CTL_CHAINED      1
`define TXMS_CTL_EARLY_CHECK  2

// event status fields
`define TXMS_ST_LATE_COL      7
`define TXMS_ST_HEARTBEAT     6
`define TXMS_ST_UNDERRUN      5
`define TXMS_ST_CARRIER_DROP  4
`define TXMS_ST_ABORT         3
`define TXMS_ST_WITH_COL      2
`define TXMS_ST_NO_DEFER      1
`define TXMS_ST_SENT          0

// reset values and limits
`define TXMS_BYTE_ZERO        8'h00
`define TXMS_WORD_ZERO        16'h0000
`define TXMS_FIFO_FREE_RESET  5'h00
`define TXMS_FIFO_FREE_EMPTY  5'h10
`define TXMS_CRC_INIT         32'hffffffff
`define TXMS_CRC_POLY         32'h04c11db7
`define TXMS_LAST_BIT         3'h7
`define TXMS_LAST_FCS_BIT     5'h1f

// timing
`define TXMS_CLK_PERIOD_NS    10
`define TXMS_HB_WINDOW_NS     3600
`define TXMS_HB_CYCLES        (`TXMS_HB_WINDOW_NS / `TXMS_CLK_PERIOD_NS)
`define TXMS_SLOT_BITS        512

`endif

// file: core/txms_pkg.sv
package txms_pkg;

	typedef enum logic [1:0] {
		TXMS_IDLE,
		TXMS_LOAD,
		TXMS_DATA,
		TXMS_FCS
	} txms_state_t;

	typedef struct packed {
		txms_state_t state;
		logic [7:0]  shift;
		logic [2:0]  bit_num;
		logic [4:0]  fcs_num;
		logic [31:0] crc;
		logic        last;
		logic [9:0]  slot_cnt;
		logic [8:0]  hb_cnt;
		logic        hb_on;
		logic        col_s1;
		logic        col_s2;
		logic        crs_s1;
		logic        crs_s2;
		logic        crs_prev;
		logic        crs_armed;
		logic        col_any;
		logic        deferred;
		logic [7:0]  status;
		logic [7:0]  table_limit;
		logic [7:0]  table_base;
		logic [15:0] desc_ptr;
		logic [15:0] frame_ptr;
		logic [15:0] remain;
		logic [15:0] length;
		logic [2:0]  ctrl;
		logic [4:0]  fifo_free;
		logic [31:0] rdata;
		logic        err;
		logic        tx_bit;
		logic        tx_en;
		logic        done;
	} txms_regs_t;

endpackage

// file: bench/txms_assertions.sv
module txms_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [8:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tx_byte_valid,
	input wire logic        tx_byte_pop,
	input wire logic        dma_byte_push,
	input wire logic        tx_pkt_done,
	input wire logic [15:0] frame_ptr,
	input wire logic [7:0]  table_limit,
	input wire logic [15:0] remain_count,
	input wire logic        fcs_inhibit
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc;
		psel && penable;
	endsequence
	sequence wr_at(logic [8:0] a);
		psel && penable && pwrite && clk_en && paddr == a;
	endsequence
	zero_wait_a: assert property (acc |-> pready)
		else $error("access phase without ready");
	upper_zero_a: assert property (acc ##0 !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	ro_refuse_a: assert property (acc ##0 pwrite && (paddr == 9'h050 || paddr == 9'h178) |-> pslverr)
		else $error("read-only write not refused");
	misalign_a: assert property (acc ##0 paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	frame_hi_a: assert property (wr_at(9'h150) |=> frame_ptr[15:8] == $past(pwdata[7:0]))
		else $error("frame pointer high not written");
	frame_hold_a: assert property (!(psel && penable && pwrite) |=> $stable(frame_ptr))
		else $error("frame pointer moved without write");
	remain_wr_a: assert property (wr_at(9'h0e8) ##0 !dma_byte_push |=> remain_count[7:0] == $past(pwdata[7:0]))
		else $error("remaining count low not written");
	limit_wr_a: assert property (wr_at(9'h0d0) |=> table_limit == $past(pwdata[7:0]))
		else $error("table limit not written");
	inhibit_wr_a: assert property (wr_at(9'h1f4) |=> fcs_inhibit == $past(pwdata[0]))
		else $error("check inhibit bit not written");
	done_pulse_a: assert property (tx_pkt_done |=> !tx_pkt_done)
		else $error("done pulse longer than one cycle");
	pop_valid_a: assert property (tx_byte_pop |-> tx_byte_valid)
		else $error("byte taken while none valid");
endmodule

bind txms_core txms_checker u_chk (.*);

// file: bench/txms_medium.sv
module txms_medium (
	input  wire logic pclk,
	input  wire logic tx_enable,
	input  wire logic col_req,
	input  wire logic drop_req,
	input  wire logic hb_req,
	output logic      collision_pin,
	output logic      carrier_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] echo = 2'h0;
	logic [3:0] hb   = 4'h0;
	always @(posedge pclk) begin
		echo <= {echo[0], tx_enable};
		if (hb_req && echo == 2'b10)
			hb <= 4'h8;
		else if (hb != 4'h0)
			hb <= hb - 4'h1;
	end
	// carrier echoes our own transmission two cycles late
	assign carrier_pin = echo[1] & ~drop_req;
	// short collision burst right after each frame when asked
	assign collision_pin = col_req | (hb != 4'h0);
endmodule

// file: bench/test_mac_transmit_dma_status.sv
module test_mac_transmit_dma_status;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [8:0] A_ST = 9'h050, A_FREE = 9'h178, A_CTL = 9'h1f4;
	localparam logic [8:0] RW_A [10] = '{9'h068, 9'h06c, 9'h0cc, 9'h0d0, 9'h0e8, 9'h0ec,
		9'h150, 9'h154, 9'h1d8, 9'h1dc};
	logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [8:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, got = 0, seed = 32'h5bde50c1;
	logic        pready, pslverr, bit_tick = 0, tx_pkt_start = 0, tx_retry = 0;
	logic        tx_chain_start = 0, tx_deferred = 0, tx_excess_abort = 0, tx_byte_pop;
	logic        tx_byte_valid = 0, tx_byte_last = 0, dma_byte_push = 0, dma_done = 0;
	logic        dma_active = 0, collision_pin, carrier_pin, tx_data, tx_enable;
	logic        tx_pkt_done, fcs_inhibit, col_req = 0, drop_req = 0, hb_req = 0;
	logic [15:0] dma_rd_addr = 0, host_wr_addr = 0, frame_ptr, desc_ptr, remain_count;
	logic [7:0]  tx_byte = 0, nb = 0, table_base, table_limit, mq [$], fq [$];
	logic [1:0]  tc = 0;
	logic [3:0]  dq = 0;
	logic [8:0]  eq [$];
	logic [39:0] frq [$];
	int          bad_count = 0, samples_checked = 0;

	txms_core u_dut (.*);
	txms_medium u_med (.*);

	initial forever #5 pclk = ~pclk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [39:0] s, input logic [39:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task final_report;
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [8:0] a, input logic [7:0] d, x, m,
		input logic e);
		logic [31:0] r;
		r = rnd();
		eq.push_back({e, x & m});
		mq.push_back(m);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {r[31:8], d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
	endtask

	task rel;
		psel <= 0;
		penable <= 0;
	endtask

	// s picks abort, carrier drop, collision; applied d cycles after start for k cycles
	task automatic send(input int n, input logic [7:0] bits, input int d = 0,
		input logic [2:0] s = 0, input int k = 0);
		logic [31:0] w;
		logic [31:0] r;
		rel;
		fq.delete();
		for (int i = 0; i < n; i++) begin
			r = rnd();
			fq.push_back(r[7:0]);
			if (i < 4)
				w[8*i+:8] = r[7:0];
		end
		if (bits != 0)
			frq.push_back({bits, w});
		repeat (2) @(posedge pclk);
		tx_pkt_start <= 1;
		@(posedge pclk);
		tx_pkt_start <= 0;
		fork
			if (s != 0) begin
				repeat (d) @(posedge pclk);
				{tx_excess_abort, drop_req, col_req} <= s;
				repeat (k) @(posedge pclk);
				{tx_excess_abort, drop_req, col_req} <= 3'h0;
			end
			do @(posedge pclk); while (tx_pkt_done !== 1'b1);
		join
		repeat (400) @(posedge pclk);
	endtask

	// byte source, bit tick and serial capture of the first 32 bits
	always @(posedge pclk) begin
		tc <= tc + 2'h1;
		bit_tick <= tc == 2'h3;
		if (tx_byte_pop === 1'b1)
			void'(fq.pop_front());
		tx_byte_valid <= fq.size() > 0;
		tx_byte_last <= fq.size() == 1;
		tx_byte <= fq.size() > 0 ? fq[0] : ~tx_byte;
		dq <= {dq[2:0], tx_pkt_done};
		if (bit_tick && tx_enable === 1'b1) begin
			if (nb < 8'd32)
				got[nb[4:0]] <= tx_data;
			nb <= nb + 8'h1;
		end
		// judged after the last bit has had its period
		if (dq[3] === 1'b1) begin
			if (frq.size() > 0)
				check({nb, got}, frq.pop_front());
			nb <= 0;
		end
	end

	always @(posedge pclk)
		if (psel && penable && pready === 1'b1)
			check(40'({pslverr, prdata[7:0] & mq.pop_front()}), 40'(eq.pop_front()));

	initial begin
		#300us;
		bad_count++;
		final_report;
	end

	initial begin
		logic [31:0] r;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, A_ST, 0, 8'h00, 8'hff, 0);
		apb(0, A_FREE, 0, 8'h00, 8'hff, 0);
		apb(0, 9'h150, 0, 8'h00, 8'hff, 0);
		apb(0, 9'h154, 0, 8'h00, 8'hff, 0);
		foreach (RW_A[i]) begin
			r = rnd();
			apb(1, RW_A[i], r[7:0], 0, 0, 0);
			apb(0, RW_A[i], 0, r[7:0], 8'hff, 0);
		end
		apb(1, A_ST, 8'hff, 0, 0, 1);
		apb(1, A_FREE, 8'h05, 0, 0, 1);
		apb(0, A_FREE, 0, 8'h00, 8'hff, 0);
		apb(0, 9'h000, 0, 0, 0, 1);
		apb(0, 9'h0d2, 0, 0, 0, 1);
		apb(1, 9'h150, 8'h21, 0, 0, 0);
		apb(1, 9'h1d8, 8'h04, 0, 0, 0);
		apb(1, 9'h1dc, 8'h00, 0, 0, 0);
		apb(1, A_CTL, 8'h01, 0, 0, 0);
		send(4, 32);
		apb(0, A_ST, 0, 8'h43, 8'hff, 0);
		apb(0, 9'h0e8, 0, 8'h04, 8'hff, 0);
		apb(1, A_CTL, 8'h00, 0, 0, 0);
		tx_deferred <= 1;
		hb_req <= 1;
		send(4, 64, 60, 3'b010, 20);
		apb(0, A_ST, 0, 8'h11, 8'hff, 0);
		tx_deferred <= 0;
		hb_req <= 0;
		send(4, 0, 60, 3'b001, 8);
		tx_retry <= 1;
		send(4, 64);
		apb(0, A_ST, 0, 8'h47, 8'hff, 0);
		tx_retry <= 0;
		send(4, 0, 60, 3'b001, 8);
		tx_retry <= 1;
		send(4, 0, 60, 3'b100, 1);
		apb(0, A_ST, 0, 8'h08, 8'h0d, 0);
		tx_retry <= 0;
		send(70, 0, 2250, 3'b001, 8);
		apb(0, A_ST, 0, 8'h80, 8'h84, 0);
		send(0, 0);
		apb(0, A_ST, 0, 8'h20, 8'h21, 0);
		dma_done <= 1;
		send(0, 0);
		dma_done <= 0;
		apb(0, A_ST, 0, 8'h43, 8'hff, 0);
		apb(1, A_CTL, 8'h04, 0, 0, 0);
		r = rnd();
		dma_rd_addr <= r[15:0];
		host_wr_addr <= r[15:0];
		dma_active <= 1;
		send(4, 64);
		dma_active <= 0;
		apb(0, A_ST, 0, 8'h20, 8'h20, 0);
		apb(1, A_CTL, 8'h02, 0, 0, 0);
		tx_chain_start <= 1;
		send(4, 64, 60, 3'b010, 20);
		tx_chain_start <= 0;
		send(4, 64);
		apb(0, A_ST, 0, 8'h10, 8'h10, 0);
		apb(0, A_FREE, 0, 8'h10, 8'hff, 0);
		rel;
		dma_byte_push <= 1;
		repeat (3) @(posedge pclk);
		clk_en <= 0;
		repeat (2) @(posedge pclk);
		{clk_en, dma_byte_push} <= 2'b10;
		apb(0, A_FREE, 0, 8'h0d, 8'hff, 0);
		rel;
		@(posedge pclk);
		final_report;
	end
endmodule
